// File: rtl/tsot_regs.svh
`ifndef TSOT_REGS_SVH
`define TSOT_REGS_SVH
`define TSOT_A_CTRL 6'h00
`define TSOT_A_CMD 6'h04
`define TSOT_A_TAG 6'h08
`define TSOT_A_ABRT 6'h0C
`define TSOT_A_SW 6'h10
`define TSOT_A_ROFS 6'h14
`define TSOT_A_RCNT 6'h18
`define TSOT_A_OSEL 6'h1C
`define TSOT_A_OTAG 6'h20
`define TSOT_A_OLEN 6'h24
`define TSOT_A_OFLG 6'h28
`define TSOT_A_LIST 6'h2C
`define TSOT_F_RDOK 0
`define TSOT_F_PRO 1
`define TSOT_F_SEG 8
`define TSOT_F_CH 8
`define TSOT_F_TLEN 10
`define TSOT_F_HASD 12
`define TSOT_CTRL_RST 32'h0000_0000
`define TSOT_SW_RST 16'h0000
`define TSOT_SW_OK 16'h9000
`define TSOT_SW_MORE 16'h62F1
`define TSOT_SW_MPRO 16'h62F2
`define TSOT_SW_P1P2 16'h6A86
`define TSOT_SW_NFND 16'h6A88
`define TSOT_SW_COND 16'h6985
`define TSOT_SW_DATA 16'h6A80
`define TSOT_SW_SEC 16'h6982
`define TSOT_SW_FILE 16'h6A82
`define TSOT_TAG_LIST 8'h5C
`define TSOT_P_LO 8'h80
`define TSOT_P_HI 8'h9E
`define TSOT_C_LO 8'hA0
`define TSOT_C_HI 8'hBE
`define TSOT_P_EXT 8'h9F
`define TSOT_C_EXT 8'hBF
`define TSOT_T2_LO 8'h1F
`define TSOT_T3_LO 8'h81
`define TSOT_LAST_HI 8'h7F
`define TSOT_L1_MAX 24'h00007F
`define TSOT_L2_MAX 24'h0000FF
`define TSOT_L3_MAX 24'h00FFFF
`define TSOT_SEG_FULL 9'h100
`define TSOT_IDX_LIST 3'h4
`endif

// File: rtl/tsot_pkg.sv
package tsot_pkg;
    typedef enum logic [1:0] {
        MD_NEXT = 2'b00,
        MD_RETX = 2'b01,
        MD_FIRST = 2'b10,
        MD_RSVD = 2'b11
    } tsot_mode_t;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EVAL = 1'b1
    } tsot_state_t;
endpackage

// File: rtl/tsot_core.sv
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "tsot_regs.svh"
module tsot_core (
    input wire logic mclk_i, // 100 MHz clock
    input wire logic rst_b_i, // Synchronous reset
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [31:0] paddr_i, // APB address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error
    output logic done_o // Command finished pulse
);
    logic [31:0] ctrl_q;
    logic [15:0] cmd_q;
    logic [23:0] tag_q;
    logic [1:0] osel_q;
    logic [23:0] otag_q [4];
    logic [1:0] otl_q [4];
    logic [23:0] olen_q [4];
    logic [1:0] oflg_q [4];
    logic act_q [4];
    logic fin_q [4];
    logic pok_q [4];
    logic [2:0] idx_q [4];
    logic [24:0] ofs_q [4];
    logic [24:0] tot_q [4];
    logic [24:0] pofs_q [4];
    logic [8:0] pcnt_q [4];
    logic [15:0] sw_q;
    logic [24:0] rofs_q;
    logic [8:0] rcnt_q;
    logic [2:0] ridx_q;
    tsot_pkg::tsot_state_t st_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic done_q;

    // Tag range check; a lone 9F or BF byte only opens a longer tag.
    function automatic logic tag_ok(input logic [1:0] n, input logic [23:0] t);
        logic [7:0] h;
        logic x;
        h = (n == 2'h2) ? t[15:8] : t[23:16];
        x = (h == `TSOT_P_EXT) || (h == `TSOT_C_EXT);
        case (n)
            2'h1: tag_ok = (t[7:0] >= `TSOT_P_LO && t[7:0] <= `TSOT_P_HI) ||
                           (t[7:0] >= `TSOT_C_LO && t[7:0] <= `TSOT_C_HI);
            2'h2: tag_ok = x && t[7:0] >= `TSOT_T2_LO && t[7:0] <= `TSOT_LAST_HI;
            2'h3: tag_ok = x && t[15:8] >= `TSOT_T3_LO && t[7:0] <= `TSOT_LAST_HI;
            default: tag_ok = 1'b0;
        endcase
    endfunction

    function automatic logic [2:0] der_n(input logic [23:0] v);
        if (v <= `TSOT_L1_MAX) begin
            der_n = 3'h1;
        end else if (v <= `TSOT_L2_MAX) begin
            der_n = 3'h2;
        end else if (v <= `TSOT_L3_MAX) begin
            der_n = 3'h3;
        end else begin
            der_n = 3'h4;
        end
    endfunction

    wire [5:0] a_w = paddr_i[5:0];
    wire map_w = (paddr_i[31:6] == 26'h0) && (a_w[1:0] == 2'h0) && (a_w <= `TSOT_A_LIST);
    wire acc_w = psel_i && penable_i && pready_q;
    wire wr_w = acc_w && pwrite_i && map_w;
    wire go_w = wr_w && a_w == `TSOT_A_CMD && st_q == tsot_pkg::ST_IDLE;
    wire eval_w = st_q == tsot_pkg::ST_EVAL;
    wire abrt_w = wr_w && a_w == `TSOT_A_ABRT;

    tsot_pkg::tsot_mode_t mode_w;
    assign mode_w = tsot_pkg::tsot_mode_t'(cmd_q[7:6]);
    wire [4:0] sfi_w = cmd_q[4:0];
    wire [1:0] ch_w = cmd_q[`TSOT_F_CH +: 2];
    wire [1:0] tl_w = cmd_q[`TSOT_F_TLEN +: 2];
    wire hasd_w = cmd_q[`TSOT_F_HASD];
    wire rdok_w = ctrl_q[`TSOT_F_RDOK];
    wire [8:0] segm_w = (ctrl_q[`TSOT_F_SEG +: 8] == 8'h00) ? `TSOT_SEG_FULL :
                        {1'b0, ctrl_q[`TSOT_F_SEG +: 8]};

    logic hit_w;
    logic [1:0] hidx_w;
    logic [3:0] list_n;
    always_comb begin
        hit_w = 1'b0;
        hidx_w = 2'h0;
        list_n = 4'h0;
        for (int i = 0; i < 4; i++) begin
            // Foreign unfinished writes count as allocated too.
            if (oflg_q[i] != 2'h0) begin
                list_n = list_n + {2'h0, otl_q[i]};
                if (otl_q[i] == tl_w && otag_q[i] == tag_q) begin
                    hit_w = 1'b1;
                    hidx_w = 2'(i);
                end
            end
        end
    end

    wire is_list = tl_w == 2'h1 && tag_q[7:0] == `TSOT_TAG_LIST;
    wire first_w = mode_w == tsot_pkg::MD_FIRST;
    wire [23:0] vlen_w = is_list ? {20'h0, list_n} : olen_q[hidx_w];
    wire [24:0] enc_w = {1'b0, vlen_w} + {23'h0, tl_w} + {22'h0, der_n(vlen_w)};

    wire e_p2 = mode_w == tsot_pkg::MD_RSVD || (!first_w && (sfi_w != 5'h0 || hasd_w));
    wire e_file = first_w && sfi_w != 5'h0;
    wire e_tag = first_w && (!hasd_w || (!is_list && !tag_ok(tl_w, tag_q)));
    wire e_nf = first_w && !is_list && !hit_w;
    wire e_lk = first_w && !is_list && hit_w && oflg_q[hidx_w][1];
    wire e_seq = mode_w == tsot_pkg::MD_NEXT && (!act_q[ch_w] || fin_q[ch_w]);
    wire e_rx = mode_w == tsot_pkg::MD_RETX && !pok_q[ch_w];

    wire [24:0] base_w = first_w ? 25'h0 : ofs_q[ch_w];
    wire [24:0] tot_w = first_w ? enc_w : tot_q[ch_w];
    wire [24:0] rem_w = tot_w - base_w;
    wire [8:0] seg_w = (rem_w > {16'h0, segm_w}) ? segm_w : rem_w[8:0];
    wire [24:0] nofs_w = base_w + {16'h0, seg_w};
    wire more_w = nofs_w < tot_w;
    wire [15:0] more_sw = ctrl_q[`TSOT_F_PRO] ? `TSOT_SW_MPRO : `TSOT_SW_MORE;

    // Checks are ordered so that parameter faults mask object faults.
    wire [15:0] sw_d = e_p2 ? `TSOT_SW_P1P2 :
                       e_file ? `TSOT_SW_FILE :
                       !rdok_w ? `TSOT_SW_SEC :
                       e_tag ? `TSOT_SW_DATA :
                       e_nf ? `TSOT_SW_NFND :
                       e_lk ? `TSOT_SW_COND :
                       (e_seq || e_rx) ? `TSOT_SW_P1P2 :
                       mode_w == tsot_pkg::MD_RETX ? (pofs_q[ch_w] + {16'h0, pcnt_q[ch_w]} <
                           tot_q[ch_w] ? more_sw : `TSOT_SW_OK) :
                       more_w ? more_sw : `TSOT_SW_OK;
    wire err_w = sw_d != `TSOT_SW_OK && sw_d != `TSOT_SW_MORE && sw_d != `TSOT_SW_MPRO;

    wire [31:0] rd_w =
        a_w == `TSOT_A_CTRL ? ctrl_q :
        a_w == `TSOT_A_CMD ? {16'h0, cmd_q} :
        a_w == `TSOT_A_TAG ? {8'h0, tag_q} :
        a_w == `TSOT_A_SW ? {15'h0, st_q == tsot_pkg::ST_EVAL, sw_q} :
        a_w == `TSOT_A_ROFS ? {ridx_q, 4'h0, rofs_q} :
        a_w == `TSOT_A_RCNT ? {23'h0, rcnt_q} :
        a_w == `TSOT_A_OSEL ? {30'h0, osel_q} :
        a_w == `TSOT_A_OTAG ? {6'h0, otl_q[osel_q], otag_q[osel_q]} :
        a_w == `TSOT_A_OLEN ? {8'h0, olen_q[osel_q]} :
        a_w == `TSOT_A_OFLG ? {30'h0, oflg_q[osel_q]} :
        a_w == `TSOT_A_LIST ? {28'h0, list_n} : 32'h0;

    // Ready comes one cycle into the access phase, so reads settle first.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= psel_i && penable_i && !pready_q;
            pslverr_q <= psel_i && penable_i && !pready_q && !map_w;
            prdata_q <= (psel_i && penable_i && !pready_q && !pwrite_i && map_w) ? rd_w : 32'h0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ctrl_q <= `TSOT_CTRL_RST;
            cmd_q <= 16'h0;
            tag_q <= 24'h0;
            osel_q <= 2'h0;
        end else if (wr_w) begin
            if (a_w == `TSOT_A_CTRL) ctrl_q <= pwdata_i;
            if (go_w) cmd_q <= pwdata_i[15:0];
            if (a_w == `TSOT_A_TAG) tag_q <= pwdata_i[23:0];
            if (a_w == `TSOT_A_OSEL) osel_q <= pwdata_i[1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 4; i++) begin
                otag_q[i] <= 24'h0;
                otl_q[i] <= 2'h0;
                olen_q[i] <= 24'h0;
                oflg_q[i] <= 2'h0;
            end
        end else if (wr_w) begin
            if (a_w == `TSOT_A_OTAG) begin
                otag_q[osel_q] <= pwdata_i[23:0];
                otl_q[osel_q] <= pwdata_i[25:24];
            end
            if (a_w == `TSOT_A_OLEN) olen_q[osel_q] <= pwdata_i[23:0];
            if (a_w == `TSOT_A_OFLG) oflg_q[osel_q] <= pwdata_i[1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_q <= tsot_pkg::ST_IDLE;
            done_q <= 1'b0;
        end else begin
            case (st_q)
                tsot_pkg::ST_IDLE: st_q <= go_w ? tsot_pkg::ST_EVAL : tsot_pkg::ST_IDLE;
                tsot_pkg::ST_EVAL: st_q <= tsot_pkg::ST_IDLE;
                default: st_q <= tsot_pkg::ST_IDLE;
            endcase
            done_q <= eval_w;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sw_q <= `TSOT_SW_RST;
            rofs_q <= 25'h0;
            rcnt_q <= 9'h0;
            ridx_q <= 3'h0;
        end else if (eval_w) begin
            sw_q <= sw_d;
            if (!err_w && mode_w == tsot_pkg::MD_RETX) begin
                rofs_q <= pofs_q[ch_w];
                rcnt_q <= pcnt_q[ch_w];
                ridx_q <= idx_q[ch_w];
            end else if (!err_w) begin
                rofs_q <= base_w;
                rcnt_q <= seg_w;
                ridx_q <= first_w ? (is_list ? `TSOT_IDX_LIST : {1'b0, hidx_w}) : idx_q[ch_w];
            end
        end
    end

    // Abort writes and command results never share a cycle on APB.
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 4; i++) begin
                act_q[i] <= 1'b0;
                fin_q[i] <= 1'b0;
                pok_q[i] <= 1'b0;
                idx_q[i] <= 3'h0;
                ofs_q[i] <= 25'h0;
                tot_q[i] <= 25'h0;
                pofs_q[i] <= 25'h0;
                pcnt_q[i] <= 9'h0;
            end
        end else if (abrt_w) begin
            for (int i = 0; i < 4; i++) begin
                if (pwdata_i[i]) begin
                    act_q[i] <= 1'b0;
                    pok_q[i] <= 1'b0;
                end
            end
        end else if (eval_w) begin
            if (err_w) begin
                pok_q[ch_w] <= 1'b0;
            end else if (mode_w != tsot_pkg::MD_RETX) begin
                act_q[ch_w] <= 1'b1;
                fin_q[ch_w] <= !more_w;
                pok_q[ch_w] <= 1'b1;
                ofs_q[ch_w] <= nofs_w;
                tot_q[ch_w] <= tot_w;
                pofs_q[ch_w] <= base_w;
                pcnt_q[ch_w] <= seg_w;
                if (first_w) idx_q[ch_w] <= is_list ? `TSOT_IDX_LIST : {1'b0, hidx_w};
            end
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign done_o = done_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_go;
        go_w ##1 eval_w;
    endsequence
    property p_go;
        s_go |=> !eval_w && done_o;
    endproperty
    a_go: assert property (p_go)
        else $error("command did not finish in one cycle");

    wire pre_ok = !e_p2 && !e_file;
    property p_sec;
        eval_w && pre_ok && !rdok_w |=> sw_q == `TSOT_SW_SEC;
    endproperty
    a_sec: assert property (p_sec)
        else $error("read denied not reported");

    property p_tag;
        eval_w && pre_ok && rdok_w && e_tag |=> sw_q == `TSOT_SW_DATA;
    endproperty
    a_tag: assert property (p_tag)
        else $error("bad tag not reported");

    property p_nf;
        eval_w && pre_ok && rdok_w && !e_tag && e_nf |=> sw_q == `TSOT_SW_NFND;
    endproperty
    a_nf: assert property (p_nf)
        else $error("absent tag not reported");

    property p_lk;
        eval_w && pre_ok && rdok_w && !e_tag && e_lk |=> sw_q == `TSOT_SW_COND;
    endproperty
    a_lk: assert property (p_lk)
        else $error("locked object not reported");

    property p_more;
        eval_w && !err_w && mode_w != tsot_pkg::MD_RETX && more_w
            |=> (sw_q == `TSOT_SW_MORE || sw_q == `TSOT_SW_MPRO) && !fin_q[ch_w];
    endproperty
    a_more: assert property (p_more)
        else $error("pending segment without more status");

    property p_fin;
        eval_w && mode_w == tsot_pkg::MD_NEXT && !e_p2 && rdok_w && fin_q[ch_w]
            |=> sw_q == `TSOT_SW_P1P2;
    endproperty
    a_fin: assert property (p_fin)
        else $error("next block after completion accepted");

    property p_keep;
        eval_w && err_w |=> ofs_q[ch_w] == $past(ofs_q[ch_w]) && !pok_q[ch_w]
            && act_q[ch_w] == $past(act_q[ch_w]);
    endproperty
    a_keep: assert property (p_keep)
        else $error("error changed transfer context");

    property p_retx;
        eval_w && !err_w && mode_w == tsot_pkg::MD_RETX
            |=> rofs_q == $past(pofs_q[ch_w]) && rcnt_q == $past(pcnt_q[ch_w]);
    endproperty
    a_retx: assert property (p_retx)
        else $error("retransmit returned other data");

    property p_first;
        eval_w && !err_w && first_w |=> act_q[ch_w] && pofs_q[ch_w] == 25'h0;
    endproperty
    a_first: assert property (p_first)
        else $error("first block did not restart transfer");

    property p_abort;
        abrt_w && pwdata_i[0] |=> !act_q[0] && !pok_q[0];
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort left transfer open");
endmodule

// File: tb/tsot_term.sv
`timescale 1ns/100ps
module tsot_term (
    input wire logic mclk_i, // Card clock
    input wire logic [31:0] prdata_i, // Read data
    input wire logic pready_i, // Ready
    input wire logic pslverr_i, // Slave error
    output logic psel_o, // Select
    output logic penable_o, // Enable
    output logic pwrite_o, // Direction
    output logic [31:0] paddr_o, // Address
    output logic [31:0] pwdata_o // Write data
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 32'h0000_0000;
        pwdata_o = 32'h0000_0000;
    end

    // The request stands until pready is seen at an edge; the slave's latency is not assumed.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= wd;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        do @(posedge mclk_i); while (pready_i !== 1'b1);
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Released data lines flip so a stale value can never pass for a live one.
        pwdata_o <= ~wd;
    endtask
endmodule

// File: tb/tlv_segmented_object_transfer_bench.sv
`timescale 1ns/100ps
`include "tsot_regs.svh"
module tlv_segmented_object_transfer_bench;
    localparam logic [7:0] FB = 8'h80;
    localparam logic [7:0] NB = 8'h00;
    localparam logic [7:0] RB = 8'h40;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, done, er;
    logic [31:0] paddr, pwdata, prdata, rv, rofs;
    logic [25:0] bad [6] = '{{2'h1, 24'h00007F}, {2'h1, 24'h00009F}, {2'h2, 24'h009F1E},
        {2'h2, 24'h009F80}, {2'h3, 24'h9F8180}, {2'h2, 24'h00BF1E}};
    logic [25:0] absent [4] = '{{2'h1, 24'h000081}, {2'h3, 24'h9FFF7F},
        {2'h1, 24'h0000BE}, {2'h2, 24'h00BF7F}};
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;

    always #5 mclk_i = ~mclk_i;

    tsot_core dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .done_o(done));
    tsot_term term (.mclk_i(mclk_i), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));

    task automatic results();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        term.xfer(1'b1, a, d, rv, er);
    endtask

    task automatic rd(input logic [31:0] a);
        term.xfer(1'b0, a, 32'h0000_0000, rv, er);
    endtask

    task automatic obj(input logic [1:0] i, input logic [1:0] tl, input logic [23:0] tag,
                       input logic [23:0] len, input logic [1:0] flg);
        wr(32'(`TSOT_A_OSEL), {30'h0, i});
        wr(32'(`TSOT_A_OTAG), {6'h00, tl, tag});
        wr(32'(`TSOT_A_OLEN), {8'h00, len});
        wr(32'(`TSOT_A_OFLG), {30'h0, flg});
    endtask

    // Offset and count are only defined for a successful reply, so errors check the status.
    task automatic run(input logic [7:0] p2, input logic [1:0] ch, input logic [1:0] tl,
                       input logic [23:0] tag, input logic [15:0] esw,
                       input logic [24:0] eofs, input logic [8:0] ecnt);
        wr(32'(`TSOT_A_TAG), {8'h00, tag});
        wr(32'(`TSOT_A_CMD), {19'h0, (p2[7:6] == 2'b10), tl, ch, p2});
        while (done !== 1'b1) @(posedge mclk_i);
        rd(32'(`TSOT_A_SW));
        check({15'h0, rv[16:0]}, {16'h0, esw});
        if (esw[15:8] == 8'h90 || esw[15:8] == 8'h62) begin
            rd(32'(`TSOT_A_ROFS));
            rofs = rv;
            check({7'h0, rv[24:0]}, {7'h0, eofs});
            rd(32'(`TSOT_A_RCNT));
            check({23'h0, rv[8:0]}, {23'h0, ecnt});
        end
    endtask

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(32'(`TSOT_A_SW));
        check(rv, 32'(`TSOT_SW_RST));
        rd(32'(`TSOT_A_CTRL));
        check(rv, `TSOT_CTRL_RST);
        rd(32'h0000_0030);
        check({31'h0, er}, 32'h0000_0001);
        check(rv, 32'h0000_0000);
        rd(32'h0000_0104);
        check({31'h0, er}, 32'h0000_0001);
        wr(32'h0000_0104, 32'h0000_1080);
        check({31'h0, er}, 32'h0000_0001);
        rd(32'(`TSOT_A_CMD));
        check(rv, 32'h0000_0000);
        obj(2'h0, 2'h1, 24'h000080, 24'h000014, 2'h1);
        obj(2'h1, 2'h2, 24'h009F1F, 24'h000005, 2'h2);
        obj(2'h2, 2'h3, 24'hBF8100, 24'h0000C8, 2'h1);
        obj(2'h3, 2'h1, 24'h0000A0, 24'h00012C, 2'h1);
        rd(32'(`TSOT_A_OTAG));
        check(rv, 32'h0100_00A0);
        run(FB, 2'h0, 2'h1, 24'h000080, `TSOT_SW_SEC, 25'h0, 9'h0);
        wr(32'(`TSOT_A_CTRL), 32'h0000_0801);
        for (int i = 0; i < 6; i++) begin
            run(FB, 2'h0, bad[i][25:24], bad[i][23:0], `TSOT_SW_DATA, 25'h0, 9'h0);
        end
        wr(32'(`TSOT_A_TAG), 32'h0000_0080);
        wr(32'(`TSOT_A_CMD), {19'h0, 1'b0, 2'h1, 2'h0, FB});
        while (done !== 1'b1) @(posedge mclk_i);
        rd(32'(`TSOT_A_SW));
        check(rv, 32'(`TSOT_SW_DATA));
        for (int i = 0; i < 4; i++) begin
            run(FB, 2'h0, absent[i][25:24], absent[i][23:0], `TSOT_SW_NFND, 25'h0, 9'h0);
        end
        run(FB, 2'h0, 2'h2, 24'h009F1F, `TSOT_SW_COND, 25'h0, 9'h0);
        run(NB, 2'h3, 2'h0, 24'h0, `TSOT_SW_P1P2, 25'h0, 9'h0);
        run(FB, 2'h0, 2'h1, 24'h000080, `TSOT_SW_MORE, 25'h0, 9'h008);
        run(NB, 2'h0, 2'h0, 24'h0, `TSOT_SW_MORE, 25'h8, 9'h008);
        run(RB, 2'h0, 2'h0, 24'h0, `TSOT_SW_MORE, 25'h8, 9'h008);
        run(FB, 2'h0, 2'h1, 24'h00007F, `TSOT_SW_DATA, 25'h0, 9'h0);
        run(NB, 2'h0, 2'h0, 24'h0, `TSOT_SW_OK, 25'h10, 9'h006);
        run(NB, 2'h0, 2'h0, 24'h0, `TSOT_SW_P1P2, 25'h0, 9'h0);
        run(RB, 2'h0, 2'h0, 24'h0, `TSOT_SW_P1P2, 25'h0, 9'h0);
        wr(32'(`TSOT_A_CTRL), 32'h0000_0803);
        run(FB, 2'h0, 2'h1, 24'h000080, `TSOT_SW_MPRO, 25'h0, 9'h008);
        rd(32'(`TSOT_A_CTRL));
        check(rv, 32'h0000_0803);
        run(FB, 2'h1, 2'h1, 24'h0000A0, `TSOT_SW_MPRO, 25'h0, 9'h008);
        run(NB, 2'h0, 2'h0, 24'h0, `TSOT_SW_MPRO, 25'h8, 9'h008);
        run(FB, 2'h0, 2'h1, 24'h000080, `TSOT_SW_MPRO, 25'h0, 9'h008);
        wr(32'(`TSOT_A_ABRT), 32'h0000_0001);
        run(NB, 2'h0, 2'h0, 24'h0, `TSOT_SW_P1P2, 25'h0, 9'h0);
        run(NB, 2'h1, 2'h0, 24'h0, `TSOT_SW_MPRO, 25'h8, 9'h008);
        wr(32'(`TSOT_A_CTRL), 32'h0000_0001);
        run(FB, 2'h2, 2'h1, 24'h0000A0, `TSOT_SW_MORE, 25'h0, 9'h100);
        run(NB, 2'h2, 2'h0, 24'h0, `TSOT_SW_OK, 25'h100, 9'h030);
        run(FB, 2'h2, 2'h3, 24'hBF8100, `TSOT_SW_OK, 25'h0, 9'h0CD);
        run(FB, 2'h2, 2'h1, 24'h000080, `TSOT_SW_OK, 25'h0, 9'h016);
        wr(32'(`TSOT_A_CTRL), 32'h0000_0801);
        run(FB, 2'h3, 2'h1, 24'h00005C, `TSOT_SW_MORE, 25'h0, 9'h008);
        check({29'h0, rofs[31:29]}, 32'(`TSOT_IDX_LIST));
        run(NB, 2'h3, 2'h0, 24'h0, `TSOT_SW_OK, 25'h8, 9'h001);
        rd(32'(`TSOT_A_LIST));
        check(rv, 32'h0000_0007);
        run(8'hC0, 2'h0, 2'h1, 24'h000080, `TSOT_SW_P1P2, 25'h0, 9'h0);
        run(8'h81, 2'h0, 2'h1, 24'h000080, `TSOT_SW_FILE, 25'h0, 9'h0);
        run(8'h01, 2'h2, 2'h0, 24'h0, `TSOT_SW_P1P2, 25'h0, 9'h0);
        results();
    end
endmodule
